// ---- design/dcap_defs.svh ----
// Purpose: offsets, field positions, reset values for the capability word
// Assumes: included by bare name
// Notes: definitions only
`ifndef DCAP_DEFS_SVH
`define DCAP_DEFS_SVH

`define DCAP_WORD_OFFSET   8'h74
`define DCAP_RESET_VALUE   32'h00008D82
`define DCAP_SCALE_MSB     27
`define DCAP_SCALE_LSB     26
`define DCAP_VALUE_MSB     25
`define DCAP_VALUE_LSB     18
`define DCAP_L1_MSB        11
`define DCAP_L1_LSB        9
`define DCAP_L0S_MSB       8
`define DCAP_L0S_LSB       6
`define DCAP_LAT_RESET     3'h6
`define DCAP_ROLE_BASED_ERROR_SUPPORT_VALUE    1'h1
`define DCAP_MAX_PAYLOAD_SUPPORTED_VALUE    3'h2
`define DCAP_MSG_SCALE_MSB 9
`define DCAP_MSG_SCALE_LSB 8
`define DCAP_MSG_VALUE_MSB 7
`define DCAP_MSG_VALUE_LSB 0
`define DCAP_GC_L1_MSB     15
`define DCAP_GC_L1_LSB     13
`define DCAP_GC_L0S_MSB    18
`define DCAP_GC_L0S_LSB    16

`endif

// ---- design/dcap_pkg.sv ----
// Purpose: types for the device capability word
// Assumes: field layout as in dcap_defs.svh
// Notes: struct packs msb first so it casts straight to the 32-bit word
package dcap_pkg;

	typedef enum logic [1:0] {
		DCAP_SCALE_1X    = 2'h0,
		DCAP_SCALE_0P1X  = 2'h1,
		DCAP_SCALE_0P01X = 2'h2,
		DCAP_SCALE_0P001X = 2'h3
	} dcap_scale_t;

	typedef struct packed {
		logic [3:0]  reserved_hi;
		dcap_scale_t captured_power_scale;
		logic [7:0]  captured_power_value;
		logic [1:0]  reserved_lo;
		logic        role_based_error_support;
		logic        power_indicator_flag;
		logic        attention_indicator_flag;
		logic        attention_button_flag;
		logic [2:0]  l1_acceptable_latency;
		logic [2:0]  l0s_acceptable_latency;
		logic        extended_tag_support;
		logic [1:0]  function_tag_extension_support;
		logic [2:0]  max_payload_supported;
	} dcap_word_t;

endpackage

// ---- design/dcap_device_capabilities.sv ----
// Purpose: read-only device capability word of the bridge config space
// Assumes: message decode and general control register live outside
// Notes: reads answer one cycle after the strobe
//
// How it works
// - bits 31:28 always read zero
// - slot power message bits 9:8 load the scale field 27:26
// - scale codes mean 1.0x, 0.1x, 0.01x, 0.001x
// - slot power message bits 7:0 load the value field 25:18
// - reserved bits 17:16 read 00b
// - bit 15 constant one, role based error reporting
// - bits 14:12 constant zero, no indicators or button
// - gen_ctrl_l1_exit_latency field mirrors general control bits 15:13
// - gen_ctrl_l1_exit_latency resets to 110b, 32 to 64 us
// - gen_ctrl_l1_exit_latency out of reset never loads below the phy's own l1 exit latency
// - gen_ctrl_l0s_exit_latency field mirrors general control bits 18:16
// - gen_ctrl_l0s_exit_latency resets to 110b, 2 to 4 us
// - gen_ctrl_l0s_exit_latency out of reset never loads below the phy's own l0s exit latency
// - bit 5 zero, no extended tags
// - bits 4:3 zero, no function tag extension
// - bits 2:0 read 010b, 512 byte payload
`timescale 1ns/100ps
`include "dcap_defs.svh"

module dcap_device_capabilities (
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        cfg_rd_in,
	input  wire logic        cfg_wr_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [31:0] cfg_wdata_in,
	input  wire logic        slot_pwr_msg_in,
	input  wire logic [9:0]  slot_pwr_payload_in,
	input  wire logic [31:0] gen_ctrl_in,
	input  wire logic [2:0]  phy_l1_exit_latency_in,
	input  wire logic [2:0]  phy_l0s_exit_latency_in,
	output logic      [31:0] cfg_rdata_out,
	output logic             cfg_rvalid_out,
	output logic      [31:0] dev_cap_word_out
);

	dcap_pkg::dcap_scale_t scale_reg;
	logic [7:0]            value_reg;
	logic [2:0]            l1_lat_reg;
	logic [2:0]            l0s_lat_reg;
	logic [2:0]            l1_lat_next;
	logic [2:0]            l0s_lat_next;
	dcap_pkg::dcap_word_t  word;

	// clamp a requested latency code to the phy's floor
	function automatic logic [2:0] lat_floor(input logic [2:0] req, input logic [2:0] floor);
		lat_floor = (req < floor) ? floor : req;
	endfunction

	// captured power fields; only the message path writes them
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			scale_reg <= dcap_pkg::DCAP_SCALE_1X;
			value_reg <= 8'h00;
		end else if (slot_pwr_msg_in) begin
			scale_reg <= dcap_pkg::dcap_scale_t'(
				slot_pwr_payload_in[`DCAP_MSG_SCALE_MSB:`DCAP_MSG_SCALE_LSB]);
			value_reg <= slot_pwr_payload_in[`DCAP_MSG_VALUE_MSB:`DCAP_MSG_VALUE_LSB];
		end
	end

	always_comb begin
		l1_lat_next  = lat_floor(gen_ctrl_in[`DCAP_GC_L1_MSB:`DCAP_GC_L1_LSB],
			phy_l1_exit_latency_in);
		l0s_lat_next = lat_floor(gen_ctrl_in[`DCAP_GC_L0S_MSB:`DCAP_GC_L0S_LSB],
			phy_l0s_exit_latency_in);
	end

	// registered mirror: field follows the control register one cycle later
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			l1_lat_reg  <= `DCAP_LAT_RESET;
			l0s_lat_reg <= `DCAP_LAT_RESET;
		end else begin
			l1_lat_reg  <= l1_lat_next;
			l0s_lat_reg <= l0s_lat_next;
		end
	end

	always_comb begin
		word                                = '0;
		word.captured_power_scale           = scale_reg;
		word.captured_power_value           = value_reg;
		word.role_based_error_support       = `DCAP_ROLE_BASED_ERROR_SUPPORT_VALUE;
		word.power_indicator_flag           = 1'h0;
		word.attention_indicator_flag       = 1'h0;
		word.attention_button_flag          = 1'h0;
		word.l1_acceptable_latency          = l1_lat_reg;
		word.l0s_acceptable_latency         = l0s_lat_reg;
		word.extended_tag_support           = 1'h0;
		word.function_tag_extension_support = 2'h0;
		word.max_payload_supported          = `DCAP_MAX_PAYLOAD_SUPPORTED_VALUE;
	end

	// writes are accepted and dropped: cfg_wr_in and data only feed the unused_wr sink
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cfg_rdata_out  <= 32'h00000000;
			cfg_rvalid_out <= 1'h0;
		end else begin
			cfg_rvalid_out <= cfg_rd_in;
			if (cfg_rd_in && cfg_addr_in == `DCAP_WORD_OFFSET)
				cfg_rdata_out <= word;
			else
				cfg_rdata_out <= 32'h00000000;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			dev_cap_word_out <= `DCAP_RESET_VALUE;
		else
			dev_cap_word_out <= word;
	end

	logic unused_wr;
	assign unused_wr = cfg_wr_in ^ (^cfg_wdata_in);

endmodule

// ---- tb/dcap_root_model.sv ----
// Purpose: upstream stand-in issuing reads, writes and power messages
// Assumes: op is entered just after a rising edge
// Notes: one op per cycle, read, write and message can share it, idle cycles carry fresh data
`timescale 1ns/100ps
module dcap_root_model (
	input  wire logic        clk_in,
	output logic             rd_out,
	output logic             wr_out,
	output logic             msg_out,
	output logic      [7:0]  a_out,
	output logic      [31:0] d_out,
	output logic      [9:0]  p_out
);
	initial {rd_out, wr_out, msg_out, a_out, d_out, p_out} = '0;
	task automatic op(logic r, w, m, logic [7:0] a, logic [31:0] d);
		{rd_out, wr_out, msg_out, a_out, d_out, p_out} = {r, w, m, a, d, d[9:0]};
		@(posedge clk_in);
	endtask
endmodule

// ---- tb/dcap_properties.sv ----
// Purpose: port checks of the capability word
// Assumes: bound into the design
// Notes: single clock domain
`timescale 1ns/100ps
module dcap_properties (
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        cfg_rd_in,
	input wire logic [7:0]  cfg_addr_in,
	input wire logic        slot_pwr_msg_in,
	input wire logic [9:0]  slot_pwr_payload_in,
	input wire logic [31:0] gen_ctrl_in,
	input wire logic [2:0]  phy_l1_exit_latency_in,
	input wire logic [2:0]  phy_l0s_exit_latency_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic        cfg_rvalid_out,
	input wire logic [31:0] dev_cap_word_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic [31:0] w = dev_cap_word_out;
	wire logic [2:0]  g1 = gen_ctrl_in[15:13];
	wire logic [2:0]  g0 = gen_ctrl_in[18:16];
	wire logic [2:0]  m1 = g1 > phy_l1_exit_latency_in ? g1 : phy_l1_exit_latency_in;
	wire logic [2:0]  m0 = g0 > phy_l0s_exit_latency_in ? g0 : phy_l0s_exit_latency_in;
	wire logic        hit = cfg_addr_in == 8'h74;
	property p_rsv; {w[31:28], w[17:16]} == 6'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_cst; {w[15:12], w[5:0]} == 10'h202; endproperty
	a_cst: assert property (p_cst) else $error("fixed bits");
	// two register stages: field register, then the registered word copy
	property p_cap; slot_pwr_msg_in |=> ##1 w[27:18] == $past(slot_pwr_payload_in, 2); endproperty
	a_cap: assert property (p_cap) else $error("capture");
	property p_hold; !slot_pwr_msg_in |=> ##1 $stable(w[27:18]); endproperty
	a_hold: assert property (p_hold) else $error("power hold");
	property p_l1; 1 |=> ##1 w[11:9] == $past(m1, 2); endproperty
	a_l1: assert property (p_l1) else $error("l1 field");
	property p_l0s; 1 |=> ##1 w[8:6] == $past(m0, 2); endproperty
	a_l0s: assert property (p_l0s) else $error("l0s field");
	// read data and the word copy load from the same fields at the same edge
	property p_rd; cfg_rd_in |=> cfg_rvalid_out && cfg_rdata_out == ($past(hit) ? w : 32'h0); endproperty
	a_rd: assert property (p_rd) else $error("read data");
	property p_idle; !cfg_rd_in |=> !cfg_rvalid_out && cfg_rdata_out == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("idle answer");
	c_msg: cover property (slot_pwr_msg_in && cfg_rd_in && hit);
	c_floor: cover property (phy_l1_exit_latency_in > g1);
	c_miss: cover property (cfg_rd_in && !hit);
endmodule
bind dcap_device_capabilities dcap_properties u_chk (.*);

// ---- tb/pcie_device_capabilities_reg_tb_top.sv ----
// Purpose: random bench with a model of the capability word
// Assumes: inputs move 1ns after the rising edge
// Notes: a mid-run reset checks the default value again
`timescale 1ns/100ps
module pcie_device_capabilities_reg_tb_top;
	logic ref_clk_in = 0, sys_rst_in = 1, cfg_rd_in, cfg_wr_in, slot_pwr_msg_in, cfg_rvalid_out;
	logic [2:0]  phy_l1_exit_latency_in = 0, phy_l0s_exit_latency_in = 0;
	logic [7:0]  cfg_addr_in;
	logic [9:0]  slot_pwr_payload_in;
	logic [31:0] gen_ctrl_in = 0, cfg_wdata_in, cfg_rdata_out, dev_cap_word_out, ew, ew_d, q[$];
	int          seed = 53181, miscompares = 0, checks_done = 0, r;
	always #5 ref_clk_in = ~ref_clk_in;
	dcap_device_capabilities uut (.*);
	dcap_root_model rc (.clk_in(ref_clk_in), .rd_out(cfg_rd_in), .wr_out(cfg_wr_in),
		.msg_out(slot_pwr_msg_in), .a_out(cfg_addr_in), .d_out(cfg_wdata_in),
		.p_out(slot_pwr_payload_in));
	function automatic logic [2:0] mx(logic [2:0] x, y);
		return x > y ? x : y;
	endfunction
	task automatic cmp(logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// reads see the word from before this edge, even beside a message
	always @(posedge ref_clk_in) begin
		if (cfg_rd_in && !sys_rst_in) q.push_back(cfg_addr_in == 8'h74 ? ew : 32'h0);
		ew <= sys_rst_in ? 32'h00008D82 : {4'h0, slot_pwr_msg_in ? slot_pwr_payload_in : ew[27:18],
			6'h08, mx(gen_ctrl_in[15:13], phy_l1_exit_latency_in),
			mx(gen_ctrl_in[18:16], phy_l0s_exit_latency_in), 6'h02};
		// the word output is one register behind the fields
		ew_d <= sys_rst_in ? 32'h00008D82 : ew;
	end
	always @(negedge ref_clk_in) if ($time > 6) begin
		cmp(dev_cap_word_out, ew_d);
		cmp(cfg_rvalid_out, q.size() > 0);
		if (q.size() > 0) cmp(cfg_rdata_out, q.pop_front());
	end
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#30000;
		miscompares++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge ref_clk_in);
		for (int i = 0; i < 600; i++) begin
			#1 r = $random(seed);
			sys_rst_in = i == 300;
			{gen_ctrl_in, phy_l1_exit_latency_in, phy_l0s_exit_latency_in} =
				{$random(seed), i == 300 ? 6'h00 : r[29:24]};
			rc.op(r[0], r[1], r[2] & r[3], r[4] ? 8'h74 : r[15:8], $random(seed));
		end
		conclude;
	end
endmodule
